/* File: hrp_cfg.svh */
// constants of the host register port: widths, strobe styles, clock counts
// assumes a single 100 MHz clock shared by both ends
`ifndef HRP_CFG_SVH
`define HRP_CFG_SVH

// ************************************************************
// widths
// ************************************************************
`define HRP_ADDR_W         5
`define HRP_DATA_W         8
`define HRP_CNT_W          4

// ************************************************************
// strobe style select levels
// ************************************************************
`define HRP_STYLE_CS       1'b1
`define HRP_STYLE_SEP      1'b0
// style, chip select, direction, read and write strobes all high: no access
`define HRP_PIN_IDLE       5'h1f

// ************************************************************
// timing counts in clocks
// ************************************************************
`define HRP_RST_HOLD_CLKS  4'h5
`define HRP_RST_RECOV_CLKS 4'h3
`define HRP_RD_MIN_CLKS    4'h3
`define HRP_WR_MIN_CLKS    4'h2
`define HRP_RD_GAP_CLKS    4'h2
`define HRP_WR_GAP_CLKS    4'h3
`define HRP_CNT_ONE        4'h1
`define HRP_CNT_ZERO       4'h0

`endif

/* File: hrp_pkg.sv */
// state types of both ends of the host register port
// assumes hrp_cfg.svh is compiled alongside
package hrp_pkg;

  // device end: idle, holding wait, wait released
  typedef enum logic [1:0] {
    HRP_D_IDLE = 2'b00,
    HRP_D_WAIT = 2'b01,
    HRP_D_DONE = 2'b10
  } hrp_dev_state_t;

  // host end: reset pulse, recovery, idle, strobe, gap
  typedef enum logic [2:0] {
    HRP_H_RESET = 3'b000,
    HRP_H_RECOV = 3'b001,
    HRP_H_IDLE  = 3'b010,
    HRP_H_ACC   = 3'b011,
    HRP_H_GAP   = 3'b100
  } hrp_host_state_t;

endpackage : hrp_pkg

/* File: hrp_if.sv */
// pins between host and device of the host register port
// assumes the testbench instantiates it and binds both ends
`timescale 1ns/1ps
`include "hrp_cfg.svh"

interface hrp_if;
  logic                   chip_select_strobe_n;
  logic                   read_not_write_dir;
  logic                   read_strobe_n;
  logic                   write_strobe_n;
  logic                   device_reset_n;
  logic                   host_strobe_style_sel;
  logic [`HRP_ADDR_W-1:0] reg_addr;
  logic                   wait_o;
  logic                   wait_oe;
  logic                   access_wait_n;
  logic [`HRP_DATA_W-1:0] host_data_o;
  logic                   host_data_oe;
  logic [`HRP_DATA_W-1:0] dev_data_o;
  logic                   dev_data_oe;
  logic [`HRP_DATA_W-1:0] host_data_bus;

  // wait is pulled high while floated
  assign access_wait_n = wait_oe ? wait_o : 1'b1;
  // device drive wins, else host drive
  assign host_data_bus = dev_data_oe ? dev_data_o : host_data_o;

  modport dev (
    input  chip_select_strobe_n, read_not_write_dir, read_strobe_n, write_strobe_n,
    input  device_reset_n, host_strobe_style_sel, reg_addr, host_data_bus,
    output wait_o, wait_oe, dev_data_o, dev_data_oe
  );

  modport host (
    output chip_select_strobe_n, read_not_write_dir, read_strobe_n, write_strobe_n,
    output device_reset_n, host_strobe_style_sel, reg_addr, host_data_o, host_data_oe,
    input  access_wait_n, host_data_bus
  );
endinterface : hrp_if

/* File: hrp_device.sv */
// device end of the host register port: decodes strobes, stretches with wait
// assumes pins arrive unsynchronised; register file sits on the user side
`timescale 1ns/1ps
`include "hrp_cfg.svh"

module hrp_device
  import hrp_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  hrp_if.dev                          pins,
  output logic                        o_rd_stb,
  output logic                        o_wr_stb,
  output logic [`HRP_ADDR_W-1:0]      o_addr,
  output logic [`HRP_DATA_W-1:0]      o_wdata,
  input  wire logic [`HRP_DATA_W-1:0] i_rdata
);

  localparam int PW = 5 + `HRP_ADDR_W + `HRP_DATA_W;

  logic                   rst_n;
  logic [PW-1:0]          pin_s1_reg;
  logic [PW-1:0]          pin_s2_reg;
  logic                   act_prev_reg;
  logic                   style;
  logic                   act;
  logic                   is_rd;
  hrp_dev_state_t         state_reg,  state_next;
  logic                   rd_reg,     rd_next;
  logic [`HRP_ADDR_W-1:0] addr_reg,   addr_next;
  logic [`HRP_DATA_W-1:0] wdata_reg,  wdata_next;
  logic [`HRP_DATA_W-1:0] rdata_reg,  rdata_next;
  logic                   rd_stb_reg, rd_stb_next;
  logic                   wr_stb_reg, wr_stb_next;

  // either the system or the host holds the device in reset
  assign rst_n = i_reset_n & pins.device_reset_n;

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      // strobes idle high so no false access follows reset
      pin_s1_reg   <= {`HRP_PIN_IDLE, {(`HRP_ADDR_W + `HRP_DATA_W){1'b0}}};
      pin_s2_reg   <= {`HRP_PIN_IDLE, {(`HRP_ADDR_W + `HRP_DATA_W){1'b0}}};
      act_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg   <= {pins.host_strobe_style_sel, pins.chip_select_strobe_n,
                       pins.read_not_write_dir, pins.read_strobe_n,
                       pins.write_strobe_n, pins.reg_addr, pins.host_data_bus};
      pin_s2_reg   <= pin_s1_reg;
      act_prev_reg <= act;
    end
  end

  // strobe decode per style
  always_comb begin
    style = pin_s2_reg[PW-1];
    if (style == `HRP_STYLE_CS) begin                              // R1
      act   = !pin_s2_reg[PW-2];
      is_rd = pin_s2_reg[PW-3];                                    // R20
    end else begin
      act   = !pin_s2_reg[PW-4] || !pin_s2_reg[PW-5];              // R1
      is_rd = !pin_s2_reg[PW-4];
    end
  end

  // ************************************************************
  // access sequencer
  // ************************************************************
  always_comb begin
    state_next  = state_reg;
    rd_next     = rd_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    rdata_next  = rdata_reg;
    rd_stb_next = 1'b0;
    wr_stb_next = 1'b0;
    case (state_reg)
      HRP_D_IDLE: begin
        if (act && !act_prev_reg) begin
          // address taken at the strobe's falling edge
          addr_next  = pin_s2_reg[`HRP_DATA_W +: `HRP_ADDR_W];     // R8 R10 R18
          rd_next    = is_rd;
          rd_stb_next = is_rd;
          state_next = HRP_D_WAIT;                                 // R21
        end
      end
      HRP_D_WAIT: begin
        // one held cycle: release lands 4 clocks after the strobe
        if (rd_reg) begin
          rdata_next = i_rdata;
        end
        state_next = act ? HRP_D_DONE : HRP_D_IDLE;                // R5 R6 R7
        wr_stb_next = !act && !rd_reg;
      end
      HRP_D_DONE: begin
        if (act) begin
          if (!rd_reg) begin
            wdata_next = pin_s2_reg[`HRP_DATA_W-1:0];              // last sample
          end
        end else begin
          wr_stb_next = !rd_reg;
          state_next  = HRP_D_IDLE;                                // R21
        end
      end
      default: begin
        state_next = HRP_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= HRP_D_IDLE;
      rd_reg     <= 1'b0;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      rdata_reg  <= '0;
      rd_stb_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      rd_reg     <= rd_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      rd_stb_reg <= rd_stb_next;
      wr_stb_reg <= wr_stb_next;
    end
  end

  // ************************************************************
  // pin drivers and user side
  // ************************************************************
  assign pins.wait_oe     = (state_reg != HRP_D_IDLE);             // R21
  assign pins.wait_o      = (state_reg == HRP_D_DONE);             // R5 R6 R7
  assign pins.dev_data_oe = (state_reg == HRP_D_DONE) && rd_reg;   // R12 R13
  assign pins.dev_data_o  = rdata_reg;
  assign o_rd_stb = rd_stb_reg;
  assign o_wr_stb = wr_stb_reg;
  assign o_addr   = addr_reg;
  assign o_wdata  = wdata_reg;

endmodule : hrp_device

/* File: hrp_host.sv */
// host end of the host register port: resets the device, runs accesses
// assumes the device end shares the clock; wait arrives unsynchronised
`timescale 1ns/1ps
`include "hrp_cfg.svh"

// Behaviour
// R1 - mode pin picks chip-select or split strobes
// R2 - reset low 5 clocks, then 3 idle
// R3 - chip select held through wait, min widths
// R4 - read strobe held through wait, min widths
// R5 - chip-select wait release 2/1 clocks minimum
// R6 - split read wait release 2 to 3 clocks
// R7 - split write wait release 1 to 2 clocks
// R8 - device takes address at chip select fall
// R9 - host takes read data at chip select rise
// R10 - device takes address at read strobe fall
// R11 - host takes read data at read strobe rise
// R12 - chip-select read data driven after 1 clock
// R13 - split read data driven after 1 clock
// R14 - read after write: 3 clocks deselected
// R15 - write strobe high during reads
// R16 - 2 clocks between read strobes
// R17 - 3 clocks between write strobes
// R18 - device takes address at write strobe fall
// R19 - read strobe high during writes
// R20 - direction high reads, stable whole access
// R21 - device holds wait low, floats after strobe
module hrp_host
  import hrp_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  hrp_if.host                         pins,
  input  wire logic                   i_style_sel,
  input  wire logic                   i_start,
  input  wire logic                   i_rnw,
  input  wire logic [`HRP_ADDR_W-1:0] i_addr,
  input  wire logic [`HRP_DATA_W-1:0] i_wdata,
  output logic                        o_ready,
  output logic                        o_done,
  output logic [`HRP_DATA_W-1:0]      o_rdata
);

  logic                   wait_s1_reg;
  logic                   wait_s2_reg;
  hrp_host_state_t        state_reg, state_next;
  logic [`HRP_CNT_W-1:0]  cnt_reg,   cnt_next;
  logic                   style_reg, style_next;
  logic                   rnw_reg,   rnw_next;
  logic                   low_reg,   low_next;
  logic [`HRP_ADDR_W-1:0] addr_reg,  addr_next;
  logic [`HRP_DATA_W-1:0] wdata_reg, wdata_next;
  logic [`HRP_DATA_W-1:0] rdata_reg, rdata_next;
  logic                   done_reg,  done_next;
  logic [`HRP_CNT_W-1:0]  min_w;
  logic [`HRP_CNT_W-1:0]  gap_w;
  logic                   acc;

  // ************************************************************
  // wait synchroniser
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_s1_reg <= 1'b1;
      wait_s2_reg <= 1'b1;
    end else begin
      wait_s1_reg <= pins.access_wait_n;
      wait_s2_reg <= wait_s1_reg;
    end
  end

  // least strobe width and recovery gap per direction
  always_comb begin
    min_w = rnw_reg ? `HRP_RD_MIN_CLKS : `HRP_WR_MIN_CLKS;         // R3 R4
    gap_w = rnw_reg ? `HRP_RD_GAP_CLKS : `HRP_WR_GAP_CLKS;         // R14 R16 R17
  end

  // ************************************************************
  // access sequencer
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + `HRP_CNT_ONE;
    style_next = style_reg;
    rnw_next   = rnw_reg;
    low_next   = low_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    done_next  = 1'b0;
    case (state_reg)
      HRP_H_RESET: begin
        if (cnt_reg == `HRP_RST_HOLD_CLKS - `HRP_CNT_ONE) begin    // R2
          cnt_next   = `HRP_CNT_ZERO;
          state_next = HRP_H_RECOV;
        end
      end
      HRP_H_RECOV: begin
        if (cnt_reg == `HRP_RST_RECOV_CLKS - `HRP_CNT_ONE) begin   // R2
          state_next = HRP_H_IDLE;
        end
      end
      HRP_H_IDLE: begin
        cnt_next = `HRP_CNT_ZERO;
        if (i_start) begin
          style_next = i_style_sel;                                // R1
          rnw_next   = i_rnw;                                      // R20
          addr_next  = i_addr;
          wdata_next = i_wdata;
          low_next   = 1'b0;
          state_next = HRP_H_ACC;
        end
      end
      HRP_H_ACC: begin
        if (!wait_s2_reg) begin
          low_next = 1'b1;
        end
        if (cnt_reg == min_w) begin
          cnt_next = cnt_reg;                                      // saturate
        end
        // end only after wait went low and came back high
        if (low_reg && wait_s2_reg
            && (cnt_reg >= min_w - `HRP_CNT_ONE)) begin            // R3 R4
          if (rnw_reg) begin
            rdata_next = pins.host_data_bus;                       // R9 R11
          end
          done_next  = 1'b1;
          cnt_next   = `HRP_CNT_ZERO;
          state_next = HRP_H_GAP;
        end
      end
      HRP_H_GAP: begin
        if (cnt_reg == gap_w - `HRP_CNT_ONE) begin                 // R14 R16 R17
          state_next = HRP_H_IDLE;
        end
      end
      default: begin
        state_next = HRP_H_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= HRP_H_RESET;
      cnt_reg   <= `HRP_CNT_ZERO;
      style_reg <= `HRP_STYLE_CS;
      rnw_reg   <= 1'b1;
      low_reg   <= 1'b0;
      addr_reg  <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      style_reg <= style_next;
      rnw_reg   <= rnw_next;
      low_reg   <= low_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      done_reg  <= done_next;
    end
  end

  // ************************************************************
  // pin drivers and user side
  // ************************************************************
  assign acc = (state_reg == HRP_H_ACC);

  // chip select strobe, or in split style the read or write strobe; the other strobes held high
  assign pins.chip_select_strobe_n = !(acc && style_reg == `HRP_STYLE_CS);           // R1
  assign pins.read_strobe_n  = !(acc && style_reg == `HRP_STYLE_SEP && rnw_reg);     // R19
  assign pins.write_strobe_n = !(acc && style_reg == `HRP_STYLE_SEP && !rnw_reg);    // R15
  assign pins.read_not_write_dir    = rnw_reg;                     // R20
  assign pins.host_strobe_style_sel = style_reg;
  assign pins.device_reset_n        = (state_reg != HRP_H_RESET);  // R2
  assign pins.reg_addr     = addr_reg;
  assign pins.host_data_o  = wdata_reg;
  assign pins.host_data_oe = acc && !rnw_reg;
  assign o_ready = (state_reg == HRP_H_IDLE);
  assign o_done  = done_reg;
  assign o_rdata = rdata_reg;

endmodule : hrp_host

/* File: hrp_monitor.sv */
// assertion monitor on the pins between host end and device end
// assumes one instance beside the hrp_if instance, same clock and reset
`timescale 1ns/1ps
`include "hrp_cfg.svh"

module hrp_monitor (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic chip_select_strobe_n,
  input wire logic read_not_write_dir,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic device_reset_n,
  input wire logic host_strobe_style_sel,
  input wire logic wait_o,
  input wire logic wait_oe,
  input wire logic access_wait_n,
  input wire logic dev_data_oe
);
  // ********
  // helpers
  // ********
  logic                  rd_act;
  logic                  wr_act;
  logic                  wait_hi;
  logic                  idle;
  logic [`HRP_CNT_W-1:0] rst_cnt_reg;
  logic [`HRP_CNT_W-1:0] rst_cnt_next;

  // access decode for either strobe style, device reset low-time
  always_comb begin
    rd_act = host_strobe_style_sel ? (!chip_select_strobe_n && read_not_write_dir)
                                   : !read_strobe_n;
    wr_act = host_strobe_style_sel ? (!chip_select_strobe_n && !read_not_write_dir)
                                   : !write_strobe_n;
    wait_hi = wait_oe && wait_o;
    idle = chip_select_strobe_n && read_strobe_n && write_strobe_n;
    rst_cnt_next = device_reset_n ? `HRP_CNT_ZERO : rst_cnt_reg + `HRP_CNT_ONE;
  end

  // counter register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_cnt_reg <= `HRP_CNT_ZERO;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // ********
  // checks
  // ********
  property p_rst_hold; $rose(device_reset_n) |-> rst_cnt_reg >= `HRP_RST_HOLD_CLKS; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("device reset too short");
  property p_rst_recov; $rose(device_reset_n) |-> idle[*3]; endproperty
  a_rst_recov: assert property (p_rst_recov) else $error("strobe too soon");
  property p_rd_wait; $rose(rd_act) |-> !wait_hi[*2] ##[1:4] wait_hi; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait release");
  property p_wr_wait; $rose(wr_act) |-> !wait_hi ##[1:5] wait_hi; endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write wait release");
  property p_rd_drive; $rose(rd_act) |-> !dev_data_oe; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("data driven early");
  property p_wait_lead; $rose(rd_act) || $rose(wr_act) |-> ##[1:4] (wait_oe && !wait_o);
  endproperty
  a_wait_lead: assert property (p_wait_lead) else $error("wait not asserted");
  property p_wait_float; idle[*5] |-> !wait_oe && !dev_data_oe; endproperty
  a_wait_float: assert property (p_wait_float) else $error("pins not floated");
  property p_excl; read_strobe_n || write_strobe_n; endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_rnw_stable;
    !chip_select_strobe_n && !$past(chip_select_strobe_n) |-> $stable(read_not_write_dir);
  endproperty
  a_rnw_stable: assert property (p_rnw_stable) else $error("direction moved");
  property p_rd_width; $rose(rd_act) |-> rd_act[*3]; endproperty
  a_rd_width: assert property (p_rd_width) else $error("read strobe short");
  property p_wr_width; $rose(wr_act) |-> wr_act[*2]; endproperty
  a_wr_width: assert property (p_wr_width) else $error("write strobe short");
  property p_hold; $rose(idle) |-> $past(wait_hi); endproperty
  a_hold: assert property (p_hold) else $error("strobe ended in wait");
  property p_rd_gap; $rose(read_strobe_n) |-> read_strobe_n[*2]; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read gap short");
  property p_wr_gap; $rose(write_strobe_n) |-> write_strobe_n[*3]; endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write gap short");
  property p_cs_gap;
    $rose(chip_select_strobe_n) && !$past(read_not_write_dir) |-> chip_select_strobe_n[*3];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("gap after write short");

  // main scenarios reached
  c_cs_rd: cover property ($rose(rd_act) && host_strobe_style_sel);
  c_sep_wr: cover property ($rose(wr_act) && !host_strobe_style_sel);
  c_rst: cover property ($rose(device_reset_n));
endmodule : hrp_monitor

/* File: hrp_bench.sv */
// self-checking bench: host end and device end joined through hrp_if
// assumes both ends share i_clk and i_reset_n
`timescale 1ns/1ps
`include "hrp_cfg.svh"

module hrp_bench;
  typedef struct packed {
    logic                   style;
    logic                   rnw;
    logic [`HRP_ADDR_W-1:0] addr;
    logic [`HRP_DATA_W-1:0] wdata;
    logic [`HRP_DATA_W-1:0] rdata;
  } hrp_row_t;

  logic                   i_clk;
  logic                   i_reset_n;
  logic                   style_sel;
  logic                   start;
  logic                   rnw;
  logic [`HRP_ADDR_W-1:0] addr;
  logic [`HRP_DATA_W-1:0] wdata;
  logic [`HRP_DATA_W-1:0] rdata_in;
  logic                   ready;
  logic                   done;
  logic [`HRP_DATA_W-1:0] rdata_out;
  logic                   rd_stb;
  logic                   wr_stb;
  logic [`HRP_ADDR_W-1:0] dev_addr;
  logic [`HRP_DATA_W-1:0] dev_wdata;
  int                     n_errors;
  int                     cmp_count;
  hrp_row_t               rows [8];

  hrp_if pins ();

  hrp_host i_hrp_host (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .pins(pins), .i_style_sel(style_sel),
    .i_start(start), .i_rnw(rnw), .i_addr(addr), .i_wdata(wdata),
    .o_ready(ready), .o_done(done), .o_rdata(rdata_out)
  );
  hrp_device i_hrp_device (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .pins(pins), .o_rd_stb(rd_stb),
    .o_wr_stb(wr_stb), .o_addr(dev_addr), .o_wdata(dev_wdata), .i_rdata(rdata_in)
  );
  hrp_monitor i_hrp_monitor (
    .i_clk(i_clk), .i_reset_n(i_reset_n),
    .chip_select_strobe_n(pins.chip_select_strobe_n),
    .read_not_write_dir(pins.read_not_write_dir), .read_strobe_n(pins.read_strobe_n),
    .write_strobe_n(pins.write_strobe_n), .device_reset_n(pins.device_reset_n),
    .host_strobe_style_sel(pins.host_strobe_style_sel), .wait_o(pins.wait_o),
    .wait_oe(pins.wait_oe), .access_wait_n(pins.access_wait_n),
    .dev_data_oe(pins.dev_data_oe)
  );

  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ********
  // tasks
  // ********
  task automatic chk_flag(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  // reset for 9 clocks, then time the span until the host is ready
  task automatic do_reset();
    int n;
    i_reset_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    #1;
    chk_flag("device reset", 1'b0, pins.device_reset_n);
    chk_flag("ready in reset", 1'b0, ready);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk_flag("recovery span", 1'b1, n >= 8 && n < 40);
    if (n >= 40) summarize();
  endtask : do_reset

  // one access through the host end; device side outputs checked
  task automatic run_row(input hrp_row_t r);
    int   n;
    logic seen;
    logic fin;
    n = 0;
    seen = 1'b0;
    fin = 1'b0;
    #1;
    while (ready !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    @(posedge i_clk);
    start <= 1'b1;
    style_sel <= r.style;
    rnw <= r.rnw;
    addr <= r.addr;
    wdata <= r.wdata;
    rdata_in <= r.rdata;
    @(posedge i_clk);
    start <= 1'b0;
    n = 0;
    while (!(seen && fin) && n < 40) begin
      #1;
      if ((rd_stb | wr_stb) === 1'b1) begin
        seen = 1'b1;
        chk_flag("read strobe", r.rnw, rd_stb);
        chk_val("address", 8'(r.addr), 8'(dev_addr));
        if (!r.rnw) chk_val("write data", r.wdata, dev_wdata);
      end
      if (done === 1'b1) begin
        fin = 1'b1;
        if (r.rnw) chk_val("read data", r.rdata, rdata_out);
      end
      @(posedge i_clk);
      n++;
    end
    chk_flag("access complete", 1'b1, seen && fin);
    if (!(seen && fin)) summarize();
  endtask : run_row

  // ********
  // sequence
  // ********
  initial begin
    i_reset_n = 1'b0;
    style_sel = 1'b1;
    start = 1'b0;
    rnw = 1'b1;
    addr = 5'h00;
    wdata = 8'h00;
    rdata_in = 8'h00;
    n_errors = 0;
    cmp_count = 0;
    // style, direction, address, write data, read data
    rows = '{'{1'b1, 1'b0, 5'h1f, 8'ha5, 8'h00}, '{1'b1, 1'b1, 5'h1f, 8'h00, 8'h3c},
             '{1'b0, 1'b0, 5'h00, 8'hff, 8'h00}, '{1'b0, 1'b1, 5'h00, 8'h00, 8'hc3},
             '{1'b0, 1'b1, 5'h15, 8'h00, 8'h5a}, '{1'b0, 1'b0, 5'h0a, 8'h81, 8'h00},
             '{1'b0, 1'b0, 5'h0b, 8'h7e, 8'h00}, '{1'b1, 1'b1, 5'h01, 8'h00, 8'hff}};
    do_reset();
    foreach (rows[i]) run_row(rows[i]);
    do_reset();
    run_row(rows[1]);
    summarize();
  end
endmodule : hrp_bench
